//--- gfm_function_mux.sv
`timescale 1ns/1ns
// four general-purpose pins with per-pin input and output functions
module gfm_function_mux (
	input wire logic clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [gfm_pkg::GFM_ADDR_W-1:0] reg_addr_i,
	input wire logic [gfm_pkg::GFM_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [gfm_pkg::GFM_DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// pins, split into level, drive and active-low enable
	input wire logic [gfm_pkg::GFM_PINS-1:0] gpio_in_i,
	output logic [gfm_pkg::GFM_PINS-1:0] gpio_out_o,
	output logic [gfm_pkg::GFM_PINS-1:0] gpio_oe_b_o,
	// status flags from the PLLs and reference monitors
	input wire logic [1:0] pll_loss_of_lock_i,
	input wire logic [1:0] pll_holdover_i,
	input wire logic [1:0] ref_loss_of_signal_i,
	// enable controls toward the clock output drivers
	output logic [gfm_pkg::GFM_CLK_OUTS-1:0] out_enable_pin_o,
	output logic [gfm_pkg::GFM_CLK_OUTS-1:0] out_enable_pin_active_o,
	// manual clock select toward the PLLs
	output logic [1:0] pll_manual_clock_select_o,
	output logic [1:0] pll_manual_clock_select_active_o
);
	import gfm_pkg::*;

	// ***************************************************************
	// register state
	// ***************************************************************
	logic [3:0] pin_direction_reg;
	logic [3:0] pin_direction_next;
	logic [3:0] in_fn2_reg;
	logic [3:0] in_fn2_next;
	logic [3:0] in_fn1_reg;
	logic [3:0] in_fn1_next;
	logic [3:0] in_fn0_reg;
	logic [3:0] in_fn0_next;
	logic [3:0] out_fn2_reg;
	logic [3:0] out_fn2_next;
	logic [3:0] out_fn1_reg;
	logic [3:0] out_fn1_next;
	logic [3:0] out_fn0_reg;
	logic [3:0] out_fn0_next;
	logic [3:0] output_value_reg;
	logic [3:0] output_value_next;
	logic [3:0] input_value_reg;
	logic [3:0] input_value_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;

	// pin-facing state
	logic [3:0] pin_out_reg;
	logic [3:0] pin_out_next;
	logic [3:0] pin_oe_b_reg;
	logic [3:0] pin_oe_b_next;
	logic [7:0] oe_level_reg;
	logic [7:0] oe_level_next;
	logic [7:0] oe_active_reg;
	logic [7:0] oe_active_next;
	logic [1:0] csel_reg;
	logic [1:0] csel_next;
	logic [1:0] csel_active_reg;
	logic [1:0] csel_active_next;

	logic [3:0] pin_sync;
	logic [3:0] flag_a;
	logic [3:0] flag_b;
	logic [3:0] is_input;
	logic [2:0] in_code [GFM_PINS];
	logic [2:0] out_code [GFM_PINS];

	// ***************************************************************
	// synchroniser
	// ***************************************************************
	gfm_sync gfm_sync_inst (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(gpio_in_i),
		.q_o(pin_sync)
	);

	// ***************************************************************
	// register port
	// ***************************************************************
	// writes keep only the low four bits; reserved bits are not stored
	always_comb begin
		pin_direction_next = pin_direction_reg;
		in_fn2_next = in_fn2_reg;
		in_fn1_next = in_fn1_reg;
		in_fn0_next = in_fn0_reg;
		out_fn2_next = out_fn2_reg;
		out_fn1_next = out_fn1_reg;
		out_fn0_next = out_fn0_reg;
		output_value_next = output_value_reg;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				GFM_OFS_PIN_DIRECTION: pin_direction_next = reg_wdata_i[3:0];
				GFM_OFS_INPUT_FUNCTION_BIT2: in_fn2_next = reg_wdata_i[3:0];
				GFM_OFS_INPUT_FUNCTION_BIT1: in_fn1_next = reg_wdata_i[3:0];
				GFM_OFS_INPUT_FUNCTION_BIT0: in_fn0_next = reg_wdata_i[3:0];
				GFM_OFS_OUTPUT_FUNCTION_BIT2: out_fn2_next = reg_wdata_i[3:0];
				GFM_OFS_OUTPUT_FUNCTION_BIT1: out_fn1_next = reg_wdata_i[3:0];
				GFM_OFS_OUTPUT_FUNCTION_BIT0: out_fn0_next = reg_wdata_i[3:0];
				GFM_OFS_OUTPUT_VALUE: output_value_next = reg_wdata_i[3:0];
				default: ; // unmapped, reserved pad and the read-only input value
			endcase
		end
		rvalid_next = reg_rd_i;
		rdata_next = GFM_RST_RDATA;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				GFM_OFS_PIN_DIRECTION: rdata_next = {4'h0, pin_direction_reg};
				GFM_OFS_INPUT_FUNCTION_BIT2: rdata_next = {4'h0, in_fn2_reg};
				GFM_OFS_INPUT_FUNCTION_BIT1: rdata_next = {4'h0, in_fn1_reg};
				GFM_OFS_INPUT_FUNCTION_BIT0: rdata_next = {4'h0, in_fn0_reg};
				GFM_OFS_OUTPUT_FUNCTION_BIT2: rdata_next = {4'h0, out_fn2_reg};
				GFM_OFS_OUTPUT_FUNCTION_BIT1: rdata_next = {4'h0, out_fn1_reg};
				GFM_OFS_OUTPUT_FUNCTION_BIT0: rdata_next = {4'h0, out_fn0_reg};
				GFM_OFS_OUTPUT_VALUE: rdata_next = {4'h0, output_value_reg};
				GFM_OFS_INPUT_VALUE: rdata_next = {4'h0, input_value_reg};
				default: rdata_next = GFM_RST_RDATA;
			endcase
		end
	end

	// ***************************************************************
	// per-pin decode
	// ***************************************************************
	// flag_a answers code 001, flag_b code 010, indexed by pin
	assign flag_a = {pll_loss_of_lock_i[1], ref_loss_of_signal_i[0], pll_holdover_i[0],
		pll_loss_of_lock_i[0]};
	assign flag_b = {ref_loss_of_signal_i[1], ref_loss_of_signal_i[1], pll_holdover_i[1],
		pll_loss_of_lock_i[1]};

	genvar g;
	generate
		for (g = 0; g < GFM_PINS; g++) begin : g_pin
			assign is_input[g] = ~pin_direction_reg[g];
			assign in_code[g] = {in_fn2_reg[g], in_fn1_reg[g], in_fn0_reg[g]};
			assign out_code[g] = {out_fn2_reg[g], out_fn1_reg[g], out_fn0_reg[g]};
			// reserved codes leave the pin low or the control inactive
			always_comb begin
				pin_oe_b_next[g] = is_input[g];
				pin_out_next[g] = 1'b0;
				if (!is_input[g]) begin
					unique case (out_code[g])
						GFM_OUT_GENERAL: pin_out_next[g] = output_value_reg[g];
						GFM_OUT_FLAG_A: pin_out_next[g] = flag_a[g];
						GFM_OUT_FLAG_B: pin_out_next[g] = flag_b[g];
						default: pin_out_next[g] = 1'b0;
					endcase
				end
				// input value clears while the pin is not a general input
				input_value_next[g] = is_input[g] && (in_code[g] == GFM_IN_GENERAL)
					&& pin_sync[g];
				oe_active_next[g] = is_input[g] && (in_code[g] == GFM_IN_OE_LOW);
				oe_active_next[g + 4] = is_input[g] && (in_code[g] == GFM_IN_OE_HIGH);
				oe_level_next[g] = oe_active_next[g] && pin_sync[g];
				oe_level_next[g + 4] = oe_active_next[g + 4] && pin_sync[g];
			end
		end
	endgenerate

	// manual clock select only exists on pins 2 and 3
	always_comb begin
		csel_active_next[0] = is_input[GFM_CSEL_PIN_PLL0]
			&& (in_code[GFM_CSEL_PIN_PLL0] == GFM_IN_CLOCK_SELECT);
		csel_active_next[1] = is_input[GFM_CSEL_PIN_PLL1]
			&& (in_code[GFM_CSEL_PIN_PLL1] == GFM_IN_CLOCK_SELECT);
		csel_next[0] = csel_active_next[0] && pin_sync[GFM_CSEL_PIN_PLL0];
		csel_next[1] = csel_active_next[1] && pin_sync[GFM_CSEL_PIN_PLL1];
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_direction_reg <= GFM_RST_FIELD;
			in_fn2_reg <= GFM_RST_FIELD;
			in_fn1_reg <= GFM_RST_FIELD;
			in_fn0_reg <= GFM_RST_FIELD;
			out_fn2_reg <= GFM_RST_FIELD;
			out_fn1_reg <= GFM_RST_FIELD;
			out_fn0_reg <= GFM_RST_FIELD;
			output_value_reg <= GFM_RST_FIELD;
			input_value_reg <= GFM_RST_FIELD;
			rdata_reg <= GFM_RST_RDATA;
			rvalid_reg <= 1'b0;
			pin_out_reg <= 4'h0;
			pin_oe_b_reg <= 4'hF;
			oe_level_reg <= 8'h00;
			oe_active_reg <= 8'h00;
			csel_reg <= 2'h0;
			csel_active_reg <= 2'h0;
		end else begin
			pin_direction_reg <= pin_direction_next;
			in_fn2_reg <= in_fn2_next;
			in_fn1_reg <= in_fn1_next;
			in_fn0_reg <= in_fn0_next;
			out_fn2_reg <= out_fn2_next;
			out_fn1_reg <= out_fn1_next;
			out_fn0_reg <= out_fn0_next;
			output_value_reg <= output_value_next;
			input_value_reg <= input_value_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			pin_out_reg <= pin_out_next;
			pin_oe_b_reg <= pin_oe_b_next;
			oe_level_reg <= oe_level_next;
			oe_active_reg <= oe_active_next;
			csel_reg <= csel_next;
			csel_active_reg <= csel_active_next;
		end
	end

	// every output straight from a flop
	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
	assign gpio_out_o = pin_out_reg;
	assign gpio_oe_b_o = pin_oe_b_reg;
	assign out_enable_pin_o = oe_level_reg;
	assign out_enable_pin_active_o = oe_active_reg;
	assign pll_manual_clock_select_o = csel_reg;
	assign pll_manual_clock_select_active_o = csel_active_reg;
endmodule : gfm_function_mux

//--- gfm_pkg.sv
package gfm_pkg;
	// ***************************************************************
	// sizes
	// ***************************************************************
	localparam int GFM_PINS = 4;
	localparam int GFM_CLK_OUTS = 8;
	localparam int GFM_ADDR_W = 16;
	localparam int GFM_DATA_W = 8;
	localparam int GFM_CODE_W = 3;

	// ***************************************************************
	// register offsets
	// ***************************************************************
	localparam logic [15:0] GFM_OFS_PIN_DIRECTION = 16'h006E;
	localparam logic [15:0] GFM_OFS_INPUT_FUNCTION_BIT2 = 16'h006F;
	localparam logic [15:0] GFM_OFS_INPUT_FUNCTION_BIT1 = 16'h0070;
	localparam logic [15:0] GFM_OFS_INPUT_FUNCTION_BIT0 = 16'h0071;
	localparam logic [15:0] GFM_OFS_OUTPUT_FUNCTION_BIT2 = 16'h0072;
	localparam logic [15:0] GFM_OFS_OUTPUT_FUNCTION_BIT1 = 16'h0073;
	localparam logic [15:0] GFM_OFS_OUTPUT_FUNCTION_BIT0 = 16'h0074;
	localparam logic [15:0] GFM_OFS_RESERVED_PAD = 16'h0075;
	localparam logic [15:0] GFM_OFS_OUTPUT_VALUE = 16'h0076;
	localparam logic [15:0] GFM_OFS_INPUT_VALUE = 16'h0219;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [3:0] GFM_RST_FIELD = 4'h0;
	localparam logic [7:0] GFM_RST_RDATA = 8'h00;

	// ***************************************************************
	// function codes
	// ***************************************************************
	localparam logic [2:0] GFM_IN_GENERAL = 3'h0;
	localparam logic [2:0] GFM_IN_OE_LOW = 3'h1;
	localparam logic [2:0] GFM_IN_OE_HIGH = 3'h2;
	localparam logic [2:0] GFM_IN_CLOCK_SELECT = 3'h5;
	localparam logic [2:0] GFM_OUT_GENERAL = 3'h0;
	localparam logic [2:0] GFM_OUT_FLAG_A = 3'h1;
	localparam logic [2:0] GFM_OUT_FLAG_B = 3'h2;

	// pins that offer the manual clock select, and the PLL each one steers
	localparam int GFM_CSEL_PIN_PLL0 = 2;
	localparam int GFM_CSEL_PIN_PLL1 = 3;
endpackage : gfm_pkg

//--- gfm_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser, one stage pair per bit
module gfm_sync (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [gfm_pkg::GFM_PINS-1:0] d_i,
	output logic [gfm_pkg::GFM_PINS-1:0] q_o
);
	import gfm_pkg::*;

	// ***************************************************************
	// stages
	// ***************************************************************
	genvar g;
	generate
		for (g = 0; g < GFM_PINS; g++) begin : g_bit
			logic meta_reg;
			logic meta_next;
			logic sync_reg;
			logic sync_next;
			// first stage is read only by the second, to keep metastability contained
			always_comb begin
				meta_next = d_i[g];
				sync_next = meta_reg;
			end
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= meta_next;
					sync_reg <= sync_next;
				end
			end
			assign q_o[g] = sync_reg;
		end
	endgenerate
endmodule : gfm_sync

//--- gfm_chk.sv
`timescale 1ns/1ns
// ****************************************
// port checker for the pin function mux
// ****************************************
module gfm_chk (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [gfm_pkg::GFM_ADDR_W-1:0] reg_addr_i,
	input wire logic [gfm_pkg::GFM_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [gfm_pkg::GFM_DATA_W-1:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic [gfm_pkg::GFM_PINS-1:0] gpio_in_i,
	input wire logic [gfm_pkg::GFM_PINS-1:0] gpio_oe_b_o,
	input wire logic [gfm_pkg::GFM_CLK_OUTS-1:0] out_enable_pin_o,
	input wire logic [gfm_pkg::GFM_CLK_OUTS-1:0] out_enable_pin_active_o,
	input wire logic [1:0] pll_manual_clock_select_o,
	input wire logic [1:0] pll_manual_clock_select_active_o
);
	import gfm_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// pin controls lag the pin by two sync stages plus the output flop
	AST_EN_VALUE: assert property (out_enable_pin_o ==
		(out_enable_pin_active_o & {2{$past(gpio_in_i, 3)}})) else $error("enable mismatch");
	AST_CSEL_VALUE: assert property (pll_manual_clock_select_o ==
		(pll_manual_clock_select_active_o & $past(gpio_in_i[3:2], 3))) else $error("select mismatch");
	// a high-enable pin has no other role, and a control pin is never driven
	AST_ONE_ROLE: assert property ((({pll_manual_clock_select_active_o, 2'h0} |
		out_enable_pin_active_o[3:0]) & out_enable_pin_active_o[7:4]) == 4'h0) else $error("two roles");
	AST_CTRL_INPUT: assert property ((({pll_manual_clock_select_active_o, 2'h0} |
		out_enable_pin_active_o[3:0] | out_enable_pin_active_o[7:4]) & ~gpio_oe_b_o) == 4'h0)
		else $error("control pin driven");
	AST_DIR_WRITE: assert property (reg_wr_i && reg_addr_i == GFM_OFS_PIN_DIRECTION |->
		##2 gpio_oe_b_o == ~$past(reg_wdata_i[3:0], 2)) else $error("direction not applied");
	// read answer comes exactly one edge after the strobe
	AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
	AST_RV_CAUSE: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray answer");
	AST_RD_UPPER: assert property (reg_rdata_o[7:4] == 4'h0 &&
		(reg_rvalid_o || reg_rdata_o == 8'h00)) else $error("read data not clean");
	COV_RD: cover property (reg_rvalid_o);
	COV_EN: cover property (|out_enable_pin_o);
	COV_CSEL: cover property (|pll_manual_clock_select_o);
endmodule : gfm_chk

bind gfm_function_mux gfm_chk gfm_chk_inst (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .gpio_in_i, .gpio_oe_b_o,
	.out_enable_pin_o, .out_enable_pin_active_o, .pll_manual_clock_select_o,
	.pll_manual_clock_select_active_o);

//--- gfm_board.sv
`timescale 1ns/1ns
// ****************************************
// board logic on the four pins
// ****************************************
module gfm_board (
	input wire logic [gfm_pkg::GFM_PINS-1:0] board_drive_i,
	input wire logic [gfm_pkg::GFM_PINS-1:0] dev_out_i,
	input wire logic [gfm_pkg::GFM_PINS-1:0] dev_oe_b_i,
	output logic [gfm_pkg::GFM_PINS-1:0] level_o
);
	import gfm_pkg::*;
	// board backs off while the device drives, so no contention is modelled
	assign level_o = (dev_oe_b_i & board_drive_i) | (~dev_oe_b_i & dev_out_i);
endmodule : gfm_board

//--- gfm_function_mux_test.sv
`timescale 1ns/1ns
module gfm_function_mux_test;
	import gfm_pkg::*;
	// ****************************************
	// stimulus and wiring
	// ****************************************
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [3:0] board_drive = 4'h0;
	logic [1:0] pll_loss_of_lock_i = 2'h0;
	logic [1:0] pll_holdover_i = 2'h0;
	logic [1:0] ref_loss_of_signal_i = 2'h0;
	logic [7:0] reg_rdata_o, out_enable_pin_o, out_enable_pin_active_o;
	logic reg_rvalid_o;
	logic [3:0] gpio_in_i, gpio_out_o, gpio_oe_b_o;
	logic [1:0] pll_manual_clock_select_o, pll_manual_clock_select_active_o;
	int err_total = 0;
	int check_count = 0;

	gfm_function_mux gfm_function_mux_inst (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .gpio_in_i, .gpio_out_o,
		.gpio_oe_b_o, .pll_loss_of_lock_i, .pll_holdover_i, .ref_loss_of_signal_i,
		.out_enable_pin_o, .out_enable_pin_active_o, .pll_manual_clock_select_o,
		.pll_manual_clock_select_active_o);
	gfm_board gfm_board_inst (.board_drive_i(board_drive), .dev_out_i(gpio_out_o),
		.dev_oe_b_i(gpio_oe_b_o), .level_o(gpio_in_i));

	// 20 MHz clock
	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wait_clk

	// writes keep reserved bits 7:4 at zero
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// answer is looked at just after the edge that registers it
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk({7'h00, reg_rvalid_o}, 8'h01);
		chk(reg_rdata_o, exp);
	endtask : rd

	task automatic drive_pins(input logic [3:0] p);
		@(posedge clk_i);
		board_drive <= p;
		wait_clk(4);
	endtask : drive_pins

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		for (int a = 16'h006E; a <= 16'h0076; a++) begin
			rd(a[15:0], 8'h00);
		end
		rd(GFM_OFS_INPUT_VALUE, 8'h00);
		chk({4'h0, gpio_oe_b_o}, 8'h0F);
	endtask : t_reset

	task automatic t_gpi;
		drive_pins(4'hA);
		rd(GFM_OFS_INPUT_VALUE, 8'h0A);
		wr(GFM_OFS_INPUT_VALUE, 8'h05);
		rd(GFM_OFS_INPUT_VALUE, 8'h0A);
		wr(GFM_OFS_RESERVED_PAD, 8'h00);
		rd(GFM_OFS_RESERVED_PAD, 8'h00);
	endtask : t_gpi

	task automatic t_inctl;
		logic [3:0] p;
		for (int c = 1; c <= 2; c++) begin
			wr(GFM_OFS_INPUT_FUNCTION_BIT0, c == 1 ? 8'h0F : 8'h00);
			wr(GFM_OFS_INPUT_FUNCTION_BIT1, c == 2 ? 8'h0F : 8'h00);
			for (int k = 0; k < 2; k++) begin
				p = k ? 4'hA : 4'h5;
				drive_pins(p);
				chk(out_enable_pin_active_o, c == 1 ? 8'h0F : 8'hF0);
				chk(out_enable_pin_o, c == 1 ? {4'h0, p} : {p, 4'h0});
			end
			rd(GFM_OFS_INPUT_VALUE, 8'h00);
		end
		wr(GFM_OFS_INPUT_FUNCTION_BIT1, 8'h00);
		wr(GFM_OFS_INPUT_FUNCTION_BIT0, 8'h0C);
		wr(GFM_OFS_INPUT_FUNCTION_BIT2, 8'h0C);
		drive_pins(4'h6);
		chk({6'h00, pll_manual_clock_select_active_o}, 8'h03);
		chk({6'h00, pll_manual_clock_select_o}, 8'h01);
		chk(out_enable_pin_active_o, 8'h00);
		rd(GFM_OFS_INPUT_VALUE, 8'h02);
		wr(GFM_OFS_INPUT_FUNCTION_BIT2, 8'h00);
		wr(GFM_OFS_INPUT_FUNCTION_BIT0, 8'h00);
	endtask : t_inctl

	task automatic t_out;
		wr(GFM_OFS_OUTPUT_VALUE, 8'h05);
		wait_clk(3);
		chk({4'h0, gpio_oe_b_o}, 8'h0F);
		wr(GFM_OFS_PIN_DIRECTION, 8'h0F);
		wait_clk(3);
		chk({4'h0, gpio_in_i}, 8'h05);
		rd(GFM_OFS_PIN_DIRECTION, 8'h0F);
		rd(GFM_OFS_OUTPUT_VALUE, 8'h05);
		rd(GFM_OFS_INPUT_VALUE, 8'h00);
		for (int c = 1; c <= 2; c++) begin
			wr(GFM_OFS_OUTPUT_FUNCTION_BIT0, c == 1 ? 8'h0F : 8'h00);
			wr(GFM_OFS_OUTPUT_FUNCTION_BIT1, c == 2 ? 8'h0F : 8'h00);
			for (int k = 0; k < 2; k++) begin
				@(posedge clk_i);
				pll_loss_of_lock_i <= k ? 2'h2 : 2'h1;
				pll_holdover_i <= k ? 2'h1 : 2'h2;
				ref_loss_of_signal_i <= k ? 2'h1 : 2'h2;
				wait_clk(3);
				// flags chosen so every pin tells its two sources apart and differs from 5
				chk({4'h0, gpio_in_i}, (c == 1) == (k == 0) ? 8'h01 : 8'h0E);
			end
		end
	endtask : t_out

	// reset in mid-run must return every pin to input and clear the controls
	task automatic t_midreset;
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		wait_clk(2);
		chk({4'h0, gpio_oe_b_o}, 8'h0F);
		chk({4'h0, gpio_out_o}, 8'h00);
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(GFM_OFS_PIN_DIRECTION, 8'h00);
		rd(GFM_OFS_OUTPUT_VALUE, 8'h00);
		rd(GFM_OFS_OUTPUT_FUNCTION_BIT0, 8'h00);
		chk({4'h0, gpio_oe_b_o}, 8'h0F);
	endtask : t_midreset

	// watchdog far beyond the roughly 140 cycles the run needs
	initial begin
		#(50 * 5000);
		err_total++;
		end_sim;
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_reset;
		t_gpi;
		t_inctl;
		t_out;
		t_midreset;
		end_sim;
	end
endmodule : gfm_function_mux_test
